// *** design/dacr_regs.sv ***
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module dacr_regs
	import dacr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [4:0]  regAddr,
	input  wire logic [7:0]  regWdata,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [7:0]  regRdata,
	input  wire logic [7:0]  eventIn,
	output logic      [11:0] chan0Value,
	output logic      [11:0] chan1Value,
	output logic      [1:0]  convStart,
	output logic      [1:0]  dmaReq,
	output logic             dacEnable,
	output logic             lowPower,
	output logic      [1:0]  chanEnable,
	output logic             internalOut,
	output logic      [1:0]  chanSelect,
	output logic      [1:0]  refSelect,
	output logic      [7:0]  gain0,
	output logic      [7:0]  offset0,
	output logic      [7:0]  gain1,
	output logic      [7:0]  offset1
);

	// ==========================================================
	// Storage
	logic [7:0] controlA;
	logic [7:0] controlB;
	logic [7:0] controlC;
	logic [7:0] trigSelect;
	logic [1:0] dataEmpty;
	logic [7:0] gainByte0;
	logic [7:0] offsetByte0;
	logic [7:0] gainByte1;
	logic [7:0] offsetByte1;
	logic [7:0] next_regRdata;
	logic [1:0] chanWritten;
	logic       alignment_select;

	dacr_chan_if chan0Link ();
	dacr_chan_if chan1Link ();

	// ==========================================================
	// Write strobes
	logic wrControlA;
	logic wrControlB;
	logic wrControlC;
	logic wrTrigSelect;
	logic wrStatus;

	assign wrControlA   = regWrite && (regAddr == OFF_CONTROL_A);
	assign wrControlB   = regWrite && (regAddr == OFF_CONTROL_B);
	assign wrControlC   = regWrite && (regAddr == OFF_CONTROL_C);
	assign wrTrigSelect = regWrite && (regAddr == OFF_TRIG_SELECT);
	assign wrStatus     = regWrite && (regAddr == OFF_STATUS);
	assign alignment_select      = controlC[POS_ALIGN];

	// ==========================================================
	// Channel data registers
	assign chan0Link.wrLow   = regWrite && (regAddr == OFF_CH0_LOW);
	assign chan0Link.wrHigh  = regWrite && (regAddr == OFF_CH0_HIGH);
	assign chan0Link.wdata   = regWdata;
	assign chan0Link.alignment_select = alignment_select;
	assign chan1Link.wrLow   = regWrite && (regAddr == OFF_CH1_LOW);
	assign chan1Link.wrHigh  = regWrite && (regAddr == OFF_CH1_HIGH);
	assign chan1Link.wdata   = regWdata;
	assign chan1Link.alignment_select = alignment_select;

	dacr_chan_data u_chan0 (
		.mclk (mclk),
		.rstn (rstn),
		.link (chan0Link.chan)
	);

	dacr_chan_data u_chan1 (
		.mclk (mclk),
		.rstn (rstn),
		.link (chan1Link.chan)
	);

	assign chanWritten = {chan1Link.written, chan0Link.written};

	// ==========================================================
	// Control registers; reserved bits are dropped so they read zero
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			controlA <= RESET_BYTE;
		end else if (wrControlA) begin
			controlA <= regWdata & MASK_CONTROL_A;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			controlB <= RESET_BYTE;
		end else if (wrControlB) begin
			controlB <= regWdata & MASK_CONTROL_B;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			controlC <= RESET_BYTE;
		end else if (wrControlC) begin
			controlC <= regWdata & MASK_CONTROL_C;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			trigSelect <= RESET_BYTE;
		end else if (wrTrigSelect) begin
			trigSelect <= regWdata & MASK_TRIG_SELECT;
		end
	end

	// ==========================================================
	// Calibration bytes
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			gainByte0 <= RESET_BYTE;
		end else if (regWrite && (regAddr == OFF_GAIN0)) begin
			gainByte0 <= regWdata;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			gainByte1 <= RESET_BYTE;
		end else if (regWrite && (regAddr == OFF_GAIN1)) begin
			gainByte1 <= regWdata;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			offsetByte0 <= RESET_BYTE;
		end else if (regWrite && (regAddr == OFF_OFFSET0)) begin
			offsetByte0 <= regWdata;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			offsetByte1 <= RESET_BYTE;
		end else if (regWrite && (regAddr == OFF_OFFSET1)) begin
			offsetByte1 <= regWdata;
		end
	end

	// ==========================================================
	// Conversion start and data-empty flags
	dacr_trigger u_trigger (
		.mclk        (mclk),
		.rstn        (rstn),
		.eventIn     (eventIn),
		.eventSelect (trigSelect[3:0]),
		.trigMode    ({controlB[POS_TRIG1], controlB[POS_TRIG0]}),
		.chanOn      ({controlA[POS_ENABLE] & controlA[POS_CH1_ON],
		               controlA[POS_ENABLE] & controlA[POS_CH0_ON]}),
		.written     (chanWritten),
		.convStart   (convStart)
	);

	// A fresh write outranks the taking of the old data: the register
	// then holds data not yet converted, so it must not look empty.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dataEmpty <= RESET_BYTE[1:0];
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (chanWritten[i]) begin
					dataEmpty[i] <= 1'b0;
				end else if (convStart[i]) begin
					dataEmpty[i] <= 1'b1;
				end else if (wrStatus) begin
					dataEmpty[i] <= regWdata[i];
				end
			end
		end
	end

	// ==========================================================
	// Read path: data only in the cycle after the strobe
	always_comb begin
		next_regRdata = 8'h00;
		if (regRead) begin
			unique case (regAddr)
				OFF_CONTROL_A:   next_regRdata = controlA;
				OFF_CONTROL_B:   next_regRdata = controlB;
				OFF_CONTROL_C:   next_regRdata = controlC;
				OFF_TRIG_SELECT: next_regRdata = trigSelect;
				OFF_STATUS:      next_regRdata = {6'h00, dataEmpty};
				OFF_GAIN0:       next_regRdata = gainByte0;
				OFF_OFFSET0:     next_regRdata = offsetByte0;
				OFF_GAIN1:       next_regRdata = gainByte1;
				OFF_OFFSET1:     next_regRdata = offsetByte1;
				OFF_CH0_LOW:     next_regRdata = chan0Link.viewLow;
				OFF_CH0_HIGH:    next_regRdata = chan0Link.viewHigh;
				OFF_CH1_LOW:     next_regRdata = chan1Link.viewLow;
				OFF_CH1_HIGH:    next_regRdata = chan1Link.viewHigh;
				default:         next_regRdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			regRdata <= RESET_BYTE;
		end else begin
			regRdata <= next_regRdata;
		end
	end

	// ==========================================================
	// Outputs to the converter
	assign chan0Value  = chan0Link.value;
	assign chan1Value  = chan1Link.value;
	assign dmaReq      = dataEmpty;
	assign dacEnable   = controlA[POS_ENABLE];
	assign lowPower    = controlA[POS_LOW_POWER];
	assign chanEnable  = {controlA[POS_CH1_ON], controlA[POS_CH0_ON]};
	assign internalOut = controlA[POS_INTERNAL_OUT];
	assign chanSelect  = controlB[POS_CHAN_SELECT +: 2];
	assign refSelect   = controlC[POS_REF_SELECT +: 2];
	assign gain0       = gainByte0;
	assign offset0     = offsetByte0;
	assign gain1       = gainByte1;
	assign offset1     = offsetByte1;

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	gain_read_a: assert property (regRead && regAddr == OFF_GAIN1
		|=> regRdata == $past(gainByte1))
		else $error("gain byte read wrong");
	offset_write_a: assert property (regWrite && regAddr == OFF_OFFSET1
		|=> offset1 == $past(regWdata))
		else $error("offset byte not stored");
	idle_read_a: assert property (!regRead |=> regRdata == 8'h00)
		else $error("read data outside its cycle");
	align_select_a: assert property (wrControlC
		|=> alignment_select == $past(regWdata[POS_ALIGN]))
		else $error("alignment select not taken");
	high_map_a: assert property (regWrite && regAddr == OFF_CH0_HIGH && !alignment_select
		|=> chan0Value[11:8] == $past(regWdata[3:0]))
		else $error("channel 0 high byte misplaced");
	eight_bit_a: assert property (regWrite && regAddr == OFF_CH1_HIGH && alignment_select
		|=> chan1Value[11:4] == $past(regWdata))
		else $error("channel 1 left high byte misplaced");
	empty_clear_a: assert property (regWrite && regAddr == OFF_CH0_HIGH
		|=> ##1 !dmaReq[0])
		else $error("empty flag not cleared by write");
	empty_set_a: assert property (convStart[1] && !chanWritten[1] |=> dmaReq[1])
		else $error("empty flag not set at conversion start");
	ctrl_hold_a: assert property (!wrControlA |=> $stable(controlA))
		else $error("control A changed without a write");
	status_read_a: assert property (regRead && regAddr == OFF_STATUS
		|=> regRdata == {6'h00, $past(dmaReq)})
		else $error("status read does not show the empty flags");
	gain_write_a: assert property (regWrite && regAddr == OFF_GAIN0
		|=> gain0 == $past(regWdata))
		else $error("gain byte not stored");
	offset_hold_a: assert property (!(regWrite && regAddr == OFF_OFFSET0)
		|=> $stable(offset0))
		else $error("offset byte changed without a write");
	low_read_a: assert property (regRead && regAddr == OFF_CH0_LOW && alignment_select
		|=> regRdata[3:0] == 4'h0)
		else $error("left low byte shows its read-only nibble");
	high_read_a: assert property (regRead && regAddr == OFF_CH1_HIGH && !alignment_select
		|=> regRdata[7:4] == 4'h0)
		else $error("right high byte shows its read-only nibble");

	left_mode_c: cover property (wrControlC && regWdata[POS_ALIGN]
		##[1:20] chan0Link.wrHigh);
	both_start_c: cover property (convStart == 2'b11);
	overwrite_c: cover property (!dmaReq[1] && chan1Link.wrHigh);
	trig_start_c: cover property (controlB[POS_TRIG1] && convStart[1]);
	status_write_c: cover property (wrStatus);

endmodule // dacr_regs

`default_nettype wire

// *** design/dacr_pkg.sv ***
package dacr_pkg;

	// ==========================================================
	// Register map
	localparam logic [4:0] OFF_CONTROL_A   = 5'h00;
	localparam logic [4:0] OFF_CONTROL_B   = 5'h01;
	localparam logic [4:0] OFF_CONTROL_C   = 5'h02;
	localparam logic [4:0] OFF_TRIG_SELECT = 5'h03;
	localparam logic [4:0] OFF_STATUS      = 5'h05;
	localparam logic [4:0] OFF_GAIN0       = 5'h08;
	localparam logic [4:0] OFF_OFFSET0     = 5'h09;
	localparam logic [4:0] OFF_GAIN1       = 5'h0A;
	localparam logic [4:0] OFF_OFFSET1     = 5'h0B;
	localparam logic [4:0] OFF_CH0_LOW     = 5'h18;
	localparam logic [4:0] OFF_CH0_HIGH    = 5'h19;
	localparam logic [4:0] OFF_CH1_LOW     = 5'h1A;
	localparam logic [4:0] OFF_CH1_HIGH    = 5'h1B;

	// ==========================================================
	// Writable bits; everything else is reserved and reads zero
	localparam logic [7:0] MASK_CONTROL_A   = 8'h1F;
	localparam logic [7:0] MASK_CONTROL_B   = 8'h63;
	localparam logic [7:0] MASK_CONTROL_C   = 8'h19;
	localparam logic [7:0] MASK_TRIG_SELECT = 8'h0F;
	localparam logic [7:0] MASK_STATUS      = 8'h03;

	// ==========================================================
	// Field positions
	localparam int POS_ENABLE       = 0;
	localparam int POS_LOW_POWER    = 1;
	localparam int POS_CH0_ON       = 2;
	localparam int POS_CH1_ON       = 3;
	localparam int POS_INTERNAL_OUT = 4;
	localparam int POS_TRIG0        = 0;
	localparam int POS_TRIG1        = 1;
	localparam int POS_CHAN_SELECT  = 5;
	localparam int POS_ALIGN        = 0;
	localparam int POS_REF_SELECT   = 3;

	// ==========================================================
	// Reset values
	localparam logic [7:0]  RESET_BYTE  = 8'h00;
	localparam logic [11:0] RESET_VALUE = 12'h000;

	// ==========================================================
	// Read views of a 12-bit value in the selected layout
	function automatic logic [7:0] dacr_low_view(input logic [11:0] v, input logic left);
		return left ? {v[3:0], 4'h0} : v[7:0];
	endfunction

	function automatic logic [7:0] dacr_high_view(input logic [11:0] v, input logic left);
		return left ? v[11:4] : {4'h0, v[11:8]};
	endfunction

endpackage

// *** design/dacr_chan_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface dacr_chan_if;
	logic        wrLow;
	logic        wrHigh;
	logic [7:0]  wdata;
	logic        alignment_select;
	logic [11:0] value;
	logic [7:0]  viewLow;
	logic [7:0]  viewHigh;
	logic        written;

	modport bank (output wrLow, output wrHigh, output wdata, output alignment_select,
		input value, input viewLow, input viewHigh, input written);
	modport chan (input wrLow, input wrHigh, input wdata, input alignment_select,
		output value, output viewLow, output viewHigh, output written);
endinterface

`default_nettype wire

// *** design/dacr_chan_data.sv ***
`timescale 1ns/100ps
`default_nettype none

module dacr_chan_data
	import dacr_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rstn,
	dacr_chan_if.chan link
);
	logic [7:0]  tempByte;
	logic [11:0] value;
	logic        written;

	// ==========================================================
	// Low byte waits in a temporary byte until the high byte lands
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tempByte <= RESET_BYTE;
		end else if (link.wrLow) begin
			tempByte <= link.alignment_select ? {link.wdata[7:4], 4'h0} : link.wdata;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			value <= RESET_VALUE;
		end else if (link.wrHigh) begin
			if (link.alignment_select) begin
				value <= {link.wdata, tempByte[7:4]};
			end else begin
				value <= {link.wdata[3:0], tempByte};
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			written <= 1'b0;
		end else begin
			written <= link.wrHigh;
		end
	end

	assign link.value    = value;
	assign link.written  = written;
	assign link.viewLow  = dacr_low_view(value, link.alignment_select);
	assign link.viewHigh = dacr_high_view(value, link.alignment_select);

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	right_load_a: assert property (link.wrHigh && !link.alignment_select |=>
		value == {$past(link.wdata[3:0]), $past(tempByte)})
		else $error("right-adjusted transfer wrong");
	left_load_a: assert property (link.wrHigh && link.alignment_select |=>
		value == {$past(link.wdata), $past(tempByte[7:4])})
		else $error("left-adjusted transfer wrong");
	low_waits_a: assert property (link.wrLow && !link.wrHigh |=> $stable(value))
		else $error("low byte write changed the value");
	left_nibble_a: assert property (link.wrLow && link.alignment_select |=> tempByte[3:0] == 4'h0)
		else $error("read-only low nibble was stored");
	written_pulse_a: assert property (link.wrHigh |=> written ##1 (written == $past(link.wrHigh)))
		else $error("written pulse wrong");

endmodule // dacr_chan_data

`default_nettype wire

// *** design/dacr_trigger.sv ***
`timescale 1ns/100ps
`default_nettype none

module dacr_trigger
	import dacr_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic [7:0] eventIn,
	input  wire logic [3:0] eventSelect,
	input  wire logic [1:0] trigMode,
	input  wire logic [1:0] chanOn,
	input  wire logic [1:0] written,
	output logic      [1:0] convStart
);
	logic [1:0] pending;
	logic [1:0] fire;
	logic [2:0] sel1;

	// Channel 1 may take the next event channel up; it wraps from 7 to 0
	assign sel1 = eventSelect[3] ? eventSelect[2:0] + 3'h1 : eventSelect[2:0];

	always_comb begin
		fire[0] = chanOn[0] & pending[0] & (~trigMode[0] | eventIn[eventSelect[2:0]]);
		fire[1] = chanOn[1] & pending[1] & (~trigMode[1] | eventIn[sel1]);
	end

	// A new write in the start cycle keeps the channel pending
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pending <= 2'b00;
		end else begin
			pending <= written | (pending & ~fire);
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			convStart <= 2'b00;
		end else begin
			convStart <= fire;
		end
	end

endmodule // dacr_trigger

`default_nettype wire

// *** test/tb_dacr_regs.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Compare: counts every check, reports a mismatch at once
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb_dacr_regs
	import dacr_pkg::*;
();
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic [4:0]  regAddr = 5'h00;
	logic [7:0]  regWdata = 8'h00;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic [7:0]  eventIn = 8'h00;
	logic [7:0]  regRdata;
	logic [11:0] chan0Value;
	logic [11:0] chan1Value;
	logic [1:0]  convStart;
	logic [1:0]  dmaReq;
	logic        dacEnable;
	logic        lowPower;
	logic        internalOut;
	logic [1:0]  chanEnable;
	logic [1:0]  chanSelect;
	logic [1:0]  refSelect;
	logic [7:0]  gain0;
	logic [7:0]  offset0;
	logic [7:0]  gain1;
	logic [7:0]  offset1;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          starts0 = 0;
	int          starts1 = 0;

	dacr_regs i_dut (
		.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .eventIn(eventIn),
		.chan0Value(chan0Value), .chan1Value(chan1Value), .convStart(convStart),
		.dmaReq(dmaReq), .dacEnable(dacEnable), .lowPower(lowPower),
		.chanEnable(chanEnable), .internalOut(internalOut), .chanSelect(chanSelect),
		.refSelect(refSelect), .gain0(gain0), .offset0(offset0), .gain1(gain1),
		.offset1(offset1)
	);

	always #25 mclk = ~mclk;

	// Start pulses last one cycle, so they are tallied rather than polled
	always @(posedge mclk) begin
		if (convStart[0] === 1'b1)
			starts0++;
		if (convStart[1] === 1'b1)
			starts1++;
	end

	// ==========================================================
	// Register bus
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask

	task automatic rdchk(input string nm, input logic [4:0] a, input logic [7:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		`CHK(nm, e, regRdata)
	endtask

	task automatic wait_starts(input int ch, input int target);
		for (int i = 0; i < 20; i++) begin
			if ((ch == 0 ? starts0 : starts1) >= target)
				break;
			// Look after the tally has run, not in the same time step
			@(posedge mclk);
			#1;
		end
	endtask

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic test_reset();
		logic [4:0] offs [8] = '{OFF_GAIN0, OFF_OFFSET0, OFF_GAIN1, OFF_OFFSET1,
			OFF_CH0_LOW, OFF_CH0_HIGH, OFF_CH1_LOW, OFF_CH1_HIGH};
		`CHK("chan0Value", 12'h000, chan0Value)
		`CHK("dmaReq", 2'b00, dmaReq)
		foreach (offs[i])
			rdchk("reset read", offs[i], 8'h00);
		@(posedge mclk);
		#1;
		`CHK("rdata idle", 8'h00, regRdata)
		$display("test_reset done");
	endtask

	task automatic test_calib();
		wr(OFF_GAIN0, 8'h81);
		wr(OFF_OFFSET0, 8'h7E);
		wr(OFF_GAIN1, 8'hC3);
		wr(OFF_OFFSET1, 8'h3C);
		wr(5'h04, 8'hFF);
		#1;
		`CHK("gain0", 8'h81, gain0)
		`CHK("offset0", 8'h7E, offset0)
		`CHK("gain1", 8'hC3, gain1)
		`CHK("offset1", 8'h3C, offset1)
		rdchk("gain1 rd", OFF_GAIN1, 8'hC3);
		rdchk("offset1 rd", OFF_OFFSET1, 8'h3C);
		rdchk("unmapped", 5'h04, 8'h00);
		$display("test_calib done");
	endtask

	task automatic test_right();
		wr(OFF_CH0_LOW, 8'hA5);
		#1;
		`CHK("low held", 12'h000, chan0Value)
		wr(OFF_CH0_HIGH, 8'h03);
		#1;
		`CHK("chan0 right", 12'h3A5, chan0Value)
		rdchk("ch0 low", OFF_CH0_LOW, 8'hA5);
		rdchk("ch0 high", OFF_CH0_HIGH, 8'h03);
		// Upper nibble of the high byte is read-only here, so it must be dropped
		wr(OFF_CH1_HIGH, 8'hF6);
		#1;
		`CHK("chan1 right", 12'h600, chan1Value)
		rdchk("ch1 high", OFF_CH1_HIGH, 8'h06);
		$display("test_right done");
	endtask

	task automatic test_left();
		wr(OFF_CONTROL_C, 8'h01);
		wr(OFF_CH1_LOW, 8'hBF);
		wr(OFF_CH1_HIGH, 8'h7C);
		#1;
		`CHK("chan1 left", 12'h7CB, chan1Value)
		rdchk("ch1 low", OFF_CH1_LOW, 8'hB0);
		rdchk("ch1 high", OFF_CH1_HIGH, 8'h7C);
		rdchk("ch0 low view", OFF_CH0_LOW, 8'h50);
		rdchk("ch0 high view", OFF_CH0_HIGH, 8'h3A);
		wr(OFF_CH1_HIGH, 8'h12);
		#1;
		`CHK("8-bit write", 12'h12B, chan1Value)
		wr(OFF_CONTROL_C, 8'h00);
		rdchk("ch1 low back", OFF_CH1_LOW, 8'h2B);
		rdchk("ch1 high back", OFF_CH1_HIGH, 8'h01);
		$display("test_left done");
	endtask

	task automatic test_convert();
		wr(OFF_CONTROL_B, 8'h02);
		wr(OFF_TRIG_SELECT, 8'h0B);
		wr(OFF_CONTROL_A, 8'h0D);
		#1;
		`CHK("enable", 1'b1, dacEnable)
		`CHK("chan on", 2'b11, chanEnable)
		repeat (6) @(posedge mclk);
		eventIn <= 8'h08;
		repeat (6) @(posedge mclk);
		#1;
		`CHK("ch1 no event", 0, starts1)
		`CHK("ch1 pending", 1'b0, dmaReq[1])
		@(posedge mclk);
		eventIn <= 8'h10;
		wait_starts(1, 1);
		@(posedge mclk);
		eventIn <= 8'h00;
		#1;
		`CHK("ch1 start", 1, starts1)
		`CHK("ch1 empty", 1'b1, dmaReq[1])
		`CHK("ch0 free start", 1, starts0)
		// Channel 0 off, so two writes pile up on one pending value
		wr(OFF_CONTROL_A, 8'h09);
		wr(OFF_CH0_HIGH, 8'h05);
		wr(OFF_CH0_HIGH, 8'h0A);
		#1;
		`CHK("overwrite", 12'hAA5, chan0Value)
		rdchk("status", OFF_STATUS, 8'h02);
		wr(OFF_CONTROL_A, 8'h0D);
		wait_starts(0, 2);
		repeat (4) @(posedge mclk);
		#1;
		`CHK("one start", 2, starts0)
		`CHK("both empty", 2'b11, dmaReq)
		$display("test_convert done");
	endtask

	task automatic test_controls();
		wr(OFF_STATUS, 8'h00);
		#1;
		`CHK("empty cleared", 2'b00, dmaReq)
		wr(OFF_STATUS, 8'h02);
		#1;
		`CHK("dma follows", 2'b10, dmaReq)
		rdchk("status wr", OFF_STATUS, 8'h02);
		wr(OFF_CONTROL_A, 8'h12);
		wr(OFF_CONTROL_B, 8'h40);
		wr(OFF_CONTROL_C, 8'h18);
		#1;
		`CHK("enable off", 1'b0, dacEnable)
		`CHK("low power", 1'b1, lowPower)
		`CHK("internal out", 1'b1, internalOut)
		`CHK("chan select", 2'b10, chanSelect)
		`CHK("ref select", 2'b11, refSelect)
		rdchk("ctrl A", OFF_CONTROL_A, 8'h12);
		rdchk("ctrl B", OFF_CONTROL_B, 8'h40);
		rdchk("ctrl C", OFF_CONTROL_C, 8'h18);
		rdchk("trig sel", OFF_TRIG_SELECT, 8'h0B);
		// Reset in mid-run must clear what earlier tests left behind
		@(posedge mclk);
		rstn <= 1'b0;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		#1;
		`CHK("rst gain1", 8'h00, gain1)
		`CHK("rst offset0", 8'h00, offset0)
		`CHK("rst chan0", 12'h000, chan0Value)
		`CHK("rst low power", 1'b0, lowPower)
		rdchk("rst ctrl C", OFF_CONTROL_C, 8'h00);
		$display("test_controls done");
	endtask

	// ==========================================================
	// Sequence and watchdog
	initial begin
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		#1;
		test_reset();
		test_calib();
		test_right();
		test_left();
		test_convert();
		test_controls();
		print_verdict();
	end

	// About 140 cycles are needed; the margin covers slow start pulses
	initial begin
		repeat (4000) @(posedge mclk);
		error_cnt++;
		$display("BAD watchdog exp %0h got %0h", 0, 1);
		print_verdict();
	end

endmodule // tb_dacr_regs

`default_nettype wire
